// ### verilog/hlt_pkg.sv
// Constants and register map of the handler limit and trigger block
package hlt_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          RLY_STEP_NS     = 1000;
    localparam int          RLY_STEP_CYC    = (RLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TRIG_OUT_NS     = 2000;
    localparam int          TRIG_OUT_CYC    = (TRIG_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int          NUM_LIMITS      = 4;
    localparam int          NUM_RELAYS      = 32;
    localparam int          LIST_LEN        = 4;

    localparam logic [11:0] CTRL_ADDR       = 12'h000;
    localparam logic [11:0] STATUS_ADDR     = 12'h004;
    localparam logic [11:0] MASK_ADDR       = 12'h008;
    localparam logic [11:0] LEVELS_ADDR     = 12'h00C;
    localparam logic [11:0] RLY_STATE_ADDR  = 12'h010;
    localparam logic [11:0] RLY_CLOSE_ADDR  = 12'h014;
    localparam logic [11:0] GLIM_BASE       = 12'h020;
    localparam logic [11:0] CLIM_BASE       = 12'h040;

    localparam int          CTRL_POL_BIT    = 0;
    localparam int          CTRL_CONT_BIT   = 1;
    localparam int          CTRL_PERCH_BIT  = 2;
    localparam int          CTRL_HOSTIF_BIT = 3;
    localparam int          CTRL_SWTRIG_BIT = 8;
    localparam int          CTRL_SRST_BIT   = 9;
    localparam logic [2:0]  CTRL_RESET      = 3'h1;

    localparam int          ST_TRIG_ACC     = 0;
    localparam int          ST_TRIG_LOCK    = 1;
    localparam int          ST_MEAS_DONE    = 2;
    localparam int          ST_LIM_FAIL     = 3;
    localparam int          ST_RLY_BLOCK    = 4;
    localparam int          NUM_EVENTS      = 5;

    localparam int          LIST_VALID_BIT  = 7;
    localparam logic [31:0] ILK_MASK        = 32'h002C_0000;
endpackage

// ### verilog/hlt_seq_if.sv
// Channel list hand-off between the register side and the relay sequencer
`timescale 1ns/100ps
interface hlt_seq_if;
    logic        start;
    logic        abort;
    logic [31:0] list;
    logic        busy;
    logic        close_valid;
    logic [4:0]  close_chan;

    modport ctrl
    (
        output start,
        output abort,
        output list,
        input  busy,
        input  close_valid,
        input  close_chan
    );
    modport seq
    (
        input  start,
        input  abort,
        input  list,
        output busy,
        output close_valid,
        output close_chan
    );
endinterface

// ### verilog/hlt_sync.sv
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/100ps
module hlt_sync
#(
    parameter int W = 1
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] filt
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end
                else
                begin
                    s1_q <= pin[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    filt[i] <= 1'b0;
                else if (s2_q == s3_q)
                    filt[i] <= s3_q;
            end
        end
    endgenerate
endmodule

// ### verilog/hlt_seq.sv
// Relay close sequencer: walks a channel list one entry per settle step
`timescale 1ns/100ps
module hlt_seq
(
    input  wire logic pclk,
    input  wire logic presetn,
    hlt_seq_if.seq    sif
);
    typedef enum logic [1:0] {HLT_IDLE = 2'b00, HLT_EMIT = 2'b01, HLT_WAIT = 2'b11} hlt_state_type;

    hlt_state_type state_q;
    logic [31:0]   list_q;
    logic [2:0]    idx_q;
    logic [15:0]   wait_q;
    logic [7:0]    entry;

    assign entry    = list_q[8*idx_q[1:0] +: 8];
    assign sif.busy = (state_q != HLT_IDLE);

    // Entries are taken strictly from byte 0 upward, one per step
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q         <= HLT_IDLE;
            list_q          <= 32'h0000_0000;
            idx_q           <= 3'h0;
            wait_q          <= 16'h0000;
            sif.close_valid <= 1'b0;
            sif.close_chan  <= 5'h00;
        end
        else
        begin
            sif.close_valid <= 1'b0;
            if (sif.abort)
                state_q <= HLT_IDLE;
            else
            begin
                unique case (state_q)
                    HLT_IDLE:
                    begin
                        if (sif.start)
                        begin
                            list_q  <= sif.list;
                            idx_q   <= 3'h0;
                            state_q <= HLT_EMIT;
                        end
                    end
                    HLT_EMIT:
                    begin
                        if (idx_q == 3'(hlt_pkg::LIST_LEN) || !entry[hlt_pkg::LIST_VALID_BIT])
                            state_q <= HLT_IDLE;
                        else
                        begin
                            sif.close_valid <= 1'b1;
                            sif.close_chan  <= entry[4:0];
                            idx_q           <= idx_q + 3'h1;
                            wait_q          <= 16'(hlt_pkg::RLY_STEP_CYC - 1);
                            state_q         <= HLT_WAIT;
                        end
                    end
                    HLT_WAIT:
                    begin
                        if (wait_q == 16'h0000)
                            state_q <= HLT_EMIT;
                        else
                            wait_q <= wait_q - 16'h0001;
                    end
                endcase
            end
        end
    end
endmodule

// ### verilog/hlt_top.sv
// Handler limit outputs, trigger gating, relay interlock and APB registers
`timescale 1ns/100ps
module hlt_top
#(
    parameter int NUM_CH = 4
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trig_dio_n,
    input  wire logic        trig_link_n,
    input  wire logic        trig_ilk,
    input  wire logic        module_ilk,
    input  wire logic        meas_done,
    input  wire logic [31:0] meas_value,
    input  wire logic [1:0]  meas_chan,
    input  wire logic        nv_host_if,
    output logic             meas_start,
    output logic [3:0]       limit_out,
    output logic             master_out,
    output logic             trig_out,
    output logic [31:0]      relay_on,
    output logic             nv_wr,
    output logic             nv_wr_val,
    output logic             irq
);
    localparam int NE = hlt_pkg::NUM_EVENTS;

    hlt_seq_if sif ();
    hlt_seq u_seq (.pclk(pclk), .presetn(presetn), .sif(sif));

    logic [3:0]  pins_f;
    hlt_sync #(.W(4)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({module_ilk, trig_ilk, trig_link_n, trig_dio_n}),
        .filt    (pins_f)
    );

    logic [2:0]    ctrl_q;
    logic          host_if_q;
    logic          nv_loaded_q;
    logic [NE-1:0] status_q;
    logic [NE-1:0] mask_q;
    logic [31:0]   glim_q [4];
    logic [31:0]   clim_q [NUM_CH*4];
    logic [3:0]    fail_q;
    logic          trig_lvl_q;
    logic [15:0]   tout_cnt_q;
    logic [31:0]   rly_q;
    logic [31:0]   rd_d;
    logic          err_d;

    wire           setup   = psel && !penable;
    wire           wr_acc  = psel && penable && pready && pwrite && !pslverr;
    wire           pol_hi  = ctrl_q[hlt_pkg::CTRL_POL_BIT];
    wire           srst    = wr_acc && paddr == hlt_pkg::CTRL_ADDR && pwdata[hlt_pkg::CTRL_SRST_BIT];
    wire           swtrig  = wr_acc && paddr == hlt_pkg::CTRL_ADDR
                             && pwdata[hlt_pkg::CTRL_SWTRIG_BIT];
    wire           ilk_ok  = pins_f[3];
    wire           trig_en = pins_f[2];
    // Either connector asserts the same trigger
    wire           trig_lvl = !(pins_f[0] && pins_f[1]);
    wire           trig_edge = trig_lvl && !trig_lvl_q;
    wire           trig_acc = trig_edge && trig_en;
    wire           trig_lock = trig_edge && !trig_en;
    wire           blk_close = sif.close_valid && !ilk_ok
                               && hlt_pkg::ILK_MASK[sif.close_chan];

    logic [3:0]    fail_d;
    always_comb
    begin
        fail_d = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            logic signed [31:0] lim;
            lim = ctrl_q[hlt_pkg::CTRL_PERCH_BIT] ? clim_q[{meas_chan, 2'(k)}] : glim_q[k];
            // Limits 0,1 are high limits, 2,3 low limits
            fail_d[k] = (k < 2) ? ($signed(meas_value) > lim) : ($signed(meas_value) < lim);
        end
    end

    always_comb
    begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr >= hlt_pkg::CLIM_BASE && paddr < 12'(hlt_pkg::CLIM_BASE + NUM_CH*16))
            rd_d = clim_q[paddr[5:2]];
        else if (paddr >= hlt_pkg::GLIM_BASE && paddr < hlt_pkg::CLIM_BASE - 12'h010)
            rd_d = glim_q[paddr[3:2]];
        else
        begin
            unique case (paddr)
                hlt_pkg::CTRL_ADDR:      rd_d = {28'h000_0000, host_if_q, ctrl_q};
                hlt_pkg::STATUS_ADDR:    rd_d = {27'h000_0000, status_q};
                hlt_pkg::MASK_ADDR:      rd_d = {27'h000_0000, mask_q};
                hlt_pkg::LEVELS_ADDR:    rd_d = {25'h000_0000, fail_q, sif.busy, ilk_ok, trig_en};
                hlt_pkg::RLY_STATE_ADDR: rd_d = rly_q;
                hlt_pkg::RLY_CLOSE_ADDR: rd_d = 32'h0000_0000;
                default:                 err_d = 1'b1;
            endcase
        end
    end

    // Zero-wait APB: answer is latched in setup, presented in access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && err_d;
            prdata  <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    // Soft reset restores defaults and one-shot mode; host choice survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= hlt_pkg::CTRL_RESET;
        else if (srst)
            ctrl_q <= hlt_pkg::CTRL_RESET;
        else if (wr_acc && paddr == hlt_pkg::CTRL_ADDR)
            ctrl_q <= pwdata[2:0];
    end

    // Host interface choice loads from and writes back to nonvolatile store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            host_if_q   <= 1'b0;
            nv_loaded_q <= 1'b0;
            nv_wr       <= 1'b0;
            nv_wr_val   <= 1'b0;
        end
        else
        begin
            nv_loaded_q <= 1'b1;
            nv_wr       <= 1'b0;
            if (!nv_loaded_q)
            begin
                host_if_q <= nv_host_if;
                nv_wr_val <= nv_host_if;
            end
            else if (wr_acc && paddr == hlt_pkg::CTRL_ADDR && !srst
                     && pwdata[hlt_pkg::CTRL_HOSTIF_BIT] != host_if_q)
            begin
                host_if_q <= pwdata[hlt_pkg::CTRL_HOSTIF_BIT];
                nv_wr_val <= pwdata[hlt_pkg::CTRL_HOSTIF_BIT];
                nv_wr     <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_acc && paddr >= hlt_pkg::GLIM_BASE && paddr < hlt_pkg::CLIM_BASE - 12'h010)
            glim_q[paddr[3:2]] <= pwdata;
        if (wr_acc && paddr >= hlt_pkg::CLIM_BASE
            && paddr < 12'(hlt_pkg::CLIM_BASE + NUM_CH*16))
            clim_q[paddr[5:2]] <= pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fail_q <= 4'h0;
        else if (srst)
            fail_q <= 4'h0;
        else if (meas_done)
            fail_q <= fail_d;
    end

    // Polarity applies to all five lines; master tracks the OR
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            limit_out  <= 4'h0;
            master_out <= 1'b0;
        end
        else
        begin
            limit_out  <= pol_hi ? fail_q : ~fail_q;
            master_out <= pol_hi ? (|fail_q) : !(|fail_q);
        end
    end

    // Filters reset low, which reads as an asserted trigger; start armed so no false edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_lvl_q <= 1'b1;
        else
            trig_lvl_q <= trig_lvl;
    end

    // Continuous mode restarts on each result; one-shot waits for a trigger
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            meas_start <= 1'b0;
        else
            meas_start <= trig_acc || swtrig
                          || (ctrl_q[hlt_pkg::CTRL_CONT_BIT] && meas_done && !srst);
    end

    // Completion pulse to the handler, stretched so slow logic sees it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tout_cnt_q <= 16'h0000;
            trig_out   <= 1'b0;
        end
        else if (meas_done)
        begin
            tout_cnt_q <= 16'(hlt_pkg::TRIG_OUT_CYC - 1);
            trig_out   <= 1'b1;
        end
        else if (tout_cnt_q != 16'h0000)
            tout_cnt_q <= tout_cnt_q - 16'h0001;
        else
            trig_out <= 1'b0;
    end

    assign sif.start = wr_acc && paddr == hlt_pkg::RLY_CLOSE_ADDR && !sif.busy;
    assign sif.abort = srst;
    assign sif.list  = pwdata;

    // Interlocked channels drop at once and cannot be closed while open
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rly_q <= 32'h0000_0000;
        else
        begin
            logic [31:0] nxt;
            nxt = rly_q;
            if (wr_acc && paddr == hlt_pkg::RLY_STATE_ADDR)
                nxt = nxt & ~pwdata;
            if (sif.close_valid && !blk_close)
                nxt[sif.close_chan] = 1'b1;
            if (srst)
                nxt = 32'h0000_0000;
            if (!ilk_ok)
                nxt = nxt & ~hlt_pkg::ILK_MASK;
            rly_q <= nxt;
        end
    end
    assign relay_on = rly_q;

    // Hardware set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= '0;
            mask_q   <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            logic [NE-1:0] ev;
            logic [NE-1:0] st;
            ev = '0;
            ev[hlt_pkg::ST_TRIG_ACC]  = trig_acc;
            ev[hlt_pkg::ST_TRIG_LOCK] = trig_lock;
            ev[hlt_pkg::ST_MEAS_DONE] = meas_done;
            ev[hlt_pkg::ST_LIM_FAIL]  = meas_done && (|fail_d);
            ev[hlt_pkg::ST_RLY_BLOCK] = blk_close;
            st = status_q;
            if (wr_acc && paddr == hlt_pkg::STATUS_ADDR)
                st = st & ~pwdata[NE-1:0];
            st = st | ev;
            status_q <= st;
            if (wr_acc && paddr == hlt_pkg::MASK_ADDR)
                mask_q <= pwdata[NE-1:0];
            irq <= |(status_q & mask_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_done;
        meas_done ##1 trig_out;
    endsequence
    sequence s_held;
        trig_out [*8];
    endsequence

    property p_master_or;
        ##1 master_out == ($past(pol_hi) ? |$past(fail_q) : !(|$past(fail_q)));
    endproperty
    a_master_or: assert property (p_master_or) else $error("master limit wrong");
    property p_pol;
        ##1 limit_out == ($past(pol_hi) ? $past(fail_q) : ~$past(fail_q));
    endproperty
    a_pol: assert property (p_pol) else $error("limit polarity wrong");
    property p_fail_hi;
        meas_done && !ctrl_q[hlt_pkg::CTRL_PERCH_BIT]
            |=> fail_q[0] == ($signed($past(meas_value)) > $signed($past(glim_q[0])));
    endproperty
    a_fail_hi: assert property (p_fail_hi) else $error("high limit compare wrong");
    property p_lockout;
        trig_edge && !trig_en && !swtrig && !(meas_done && ctrl_q[1]) |=> !meas_start;
    endproperty
    a_lockout: assert property (p_lockout) else $error("trigger passed interlock");
    property p_accept;
        trig_edge && trig_en |=> meas_start;
    endproperty
    a_accept: assert property (p_accept) else $error("trigger not accepted");
    property p_once;
        trig_acc |=> !trig_acc [*2];
    endproperty
    a_once: assert property (p_once) else $error("trigger edge seen twice");
    property p_trigout;
        s_done |-> s_held;
    endproperty
    a_trigout: assert property (p_trigout) else $error("trigger out too short");
    property p_ilk;
        !ilk_ok |=> (rly_q & hlt_pkg::ILK_MASK) == 32'h0000_0000;
    endproperty
    a_ilk: assert property (p_ilk) else $error("interlocked relay closed");
    property p_step;
        sif.close_valid |=> !sif.close_valid [*8];
    endproperty
    a_step: assert property (p_step) else $error("relays closed too close");
    property p_srst;
        srst |=> !ctrl_q[hlt_pkg::CTRL_CONT_BIT] && rly_q == 32'h0000_0000;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset incomplete");
    property p_nv;
        nv_wr |-> nv_wr_val == host_if_q;
    endproperty
    a_nv: assert property (p_nv) else $error("nv write value wrong");
endmodule

// ### sim/hlt_handler.sv
// Handler model: shield switch, trigger drivers and finished-test counter
`timescale 1ns/100ps
module hlt_handler
(
    input  wire logic pclk,
    input  wire logic shield_open,
    input  wire logic fire_dio,
    input  wire logic fire_link,
    input  wire logic trig_out,
    output logic      trig_dio_n,
    output logic      trig_link_n,
    output logic      trig_ilk,
    output logic      module_ilk,
    output int        done_count
);
    logic trig_out_q;

    assign trig_ilk    = ~shield_open;
    assign module_ilk  = ~shield_open;
    assign trig_dio_n  = ~fire_dio;
    assign trig_link_n = ~fire_link;

    initial done_count = 0;
    initial trig_out_q = 1'b0;

    // A long done strobe counts once, as a real handler would see it
    always @(posedge pclk)
    begin
        trig_out_q <= trig_out;
        if (trig_out === 1'b1 && trig_out_q !== 1'b1)
            done_count <= done_count + 1;
    end
endmodule

// ### sim/hlt_top_tb.sv
// Self-checking bench for the handler limit and trigger block
`timescale 1ns/100ps
module hlt_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, m;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, relay_on, rv, meas_value;
    logic        meas_done, nv_host_if, meas_start, master_out, trig_out, nv_wr, nv_wr_val;
    logic        irq, trig_dio_n, trig_link_n, trig_ilk, module_ilk;
    logic        shield_open, fire_dio, fire_link;
    logic [1:0]  meas_chan;
    logic [3:0]  limit_out, f;
    int          err_count, num_checks, cyc, starts, nv_pulses, done_count, n0;
    logic signed [31:0] glim [4] = '{100, 200, -100, -200};
    logic signed [31:0] clim [4] = '{10, 20, -10, -20};
    logic signed [31:0] lim  [4];
    logic [2:0]  cs_ctrl [6] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h5, 3'h4};
    int          cs_val  [6] = '{150, -300, 0, 250, 15, -15};

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    hlt_top #(.NUM_CH(4)) DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_dio_n(trig_dio_n), .trig_link_n(trig_link_n), .trig_ilk(trig_ilk),
        .module_ilk(module_ilk), .meas_done(meas_done), .meas_value(meas_value),
        .meas_chan(meas_chan), .nv_host_if(nv_host_if), .meas_start(meas_start),
        .limit_out(limit_out), .master_out(master_out), .trig_out(trig_out),
        .relay_on(relay_on), .nv_wr(nv_wr), .nv_wr_val(nv_wr_val), .irq(irq)
    );

    hlt_handler HND
    (
        .pclk(pclk), .shield_open(shield_open), .fire_dio(fire_dio), .fire_link(fire_link),
        .trig_out(trig_out), .trig_dio_n(trig_dio_n), .trig_link_n(trig_link_n),
        .trig_ilk(trig_ilk), .module_ilk(module_ilk), .done_count(done_count)
    );

    task automatic tally_and_finish;
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic meas(input logic [31:0] v, input logic [1:0] ch);
        @(posedge pclk);
        meas_done <= 1'b1;
        meas_value <= v;
        meas_chan <= ch;
        @(posedge pclk);
        meas_done <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic fire(input logic link);
        @(posedge pclk);
        fire_dio <= ~link;
        fire_link <= link;
        repeat (20) @(posedge pclk);
        fire_dio <= 1'b0;
        fire_link <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (meas_start === 1'b1)
            starts <= starts + 1;
        if (nv_wr === 1'b1)
            nv_pulses <= nv_pulses + 1;
        if (cyc == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {meas_done, meas_value, meas_chan, nv_host_if} = '0;
        {shield_open, fire_dio, fire_link} = '0;
        {err_count, num_checks, cyc, starts, nv_pulses} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Pin filters need a few edges before the interlocks read true
        repeat (6) @(posedge pclk);
        apb(1'b0, hlt_pkg::CTRL_ADDR, 32'h0000_0000);
        chk(rv[2:0], hlt_pkg::CTRL_RESET);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, hlt_pkg::GLIM_BASE + 12'(4 * k), glim[k]);
            apb(1'b1, hlt_pkg::CLIM_BASE + 12'(32 + 4 * k), clim[k]);
        end
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, hlt_pkg::CTRL_ADDR, {29'h0, cs_ctrl[i]});
            meas(cs_val[i], {cs_ctrl[i][2], 1'b0});
            for (int k = 0; k < 4; k++)
                lim[k] = cs_ctrl[i][2] ? clim[k] : glim[k];
            f = {cs_val[i] < lim[3], cs_val[i] < lim[2], cs_val[i] > lim[1], cs_val[i] > lim[0]};
            m = cs_ctrl[i][0] ^ (f == 4'h0);
            if (!cs_ctrl[i][0])
                f = ~f;
            chk(limit_out, f);
            chk(master_out, m);
            chk(trig_out, 1);
            repeat (hlt_pkg::TRIG_OUT_CYC) @(posedge pclk);
            chk(trig_out, 0);
        end
        chk(done_count, 6);
        apb(1'b1, hlt_pkg::CTRL_ADDR, 32'h0000_0001);
        apb(1'b1, hlt_pkg::MASK_ADDR, 32'h0000_0004);
        apb(1'b1, hlt_pkg::STATUS_ADDR, 32'h0000_001F);
        apb(1'b0, hlt_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(rv, 0);
        chk(irq, 0);
        meas(32'h0000_0000, 2'h0);
        chk(irq, 1);
        apb(1'b1, hlt_pkg::STATUS_ADDR, 32'h0000_0004);
        apb(1'b0, hlt_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(rv[2], 0);
        chk(irq, 0);
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        chk(er, 1);
        shield_open <= 1'b1;
        repeat (10) @(posedge pclk);
        n0 = starts;
        fire(1'b0);
        chk(starts, n0);
        apb(1'b0, hlt_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(rv[1], 1);
        shield_open <= 1'b0;
        repeat (10) @(posedge pclk);
        fire(1'b0);
        chk(starts, n0 + 1);
        fire(1'b1);
        chk(starts, n0 + 2);
        apb(1'b1, hlt_pkg::CTRL_ADDR, 32'h0000_0003);
        meas(32'h0000_0000, 2'h0);
        chk(starts, n0 + 3);
        apb(1'b1, hlt_pkg::CTRL_ADDR, 32'h0000_0101);
        repeat (3) @(posedge pclk);
        chk(starts, n0 + 4);
        meas(32'h0000_0000, 2'h0);
        chk(starts, n0 + 4);
        apb(1'b0, hlt_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(rv[0], 1);
        shield_open <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b1, hlt_pkg::RLY_CLOSE_ADDR, 32'h0000_8392);
        repeat (3 * hlt_pkg::RLY_STEP_CYC) @(posedge pclk);
        chk(relay_on, 32'h0000_0008);
        apb(1'b0, hlt_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(rv[4], 1);
        shield_open <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, hlt_pkg::RLY_CLOSE_ADDR, 32'h0000_9285);
        repeat (hlt_pkg::RLY_STEP_CYC / 2) @(posedge pclk);
        chk(relay_on, 32'h0000_0028);
        repeat (hlt_pkg::RLY_STEP_CYC) @(posedge pclk);
        chk(relay_on, 32'h0004_0028);
        shield_open <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(relay_on, 32'h0000_0028);
        apb(1'b1, hlt_pkg::CTRL_ADDR, 32'h0000_0009);
        repeat (3) @(posedge pclk);
        chk(nv_pulses, 1);
        chk(nv_wr_val, 1);
        apb(1'b1, hlt_pkg::CTRL_ADDR, 32'h0000_0208);
        repeat (3) @(posedge pclk);
        chk(relay_on, 0);
        apb(1'b0, hlt_pkg::CTRL_ADDR, 32'h0000_0000);
        chk(rv[2:0], hlt_pkg::CTRL_RESET);
        tally_and_finish();
    end
endmodule
